// [sim/sbst_jtag_ctl.sv]
// Test controller model: drives test clock, mode and data pins.
// Assumes mclk from the bench; test clock is 12 mclk (48 ns) a period.
`timescale 1ns/1ps
module sbst_jtag_ctl (
	// Clock
	input  wire logic        mclk,
	// Test pins
	output logic             tck,
	output logic             tms,
	output logic             tdi,
	input  wire logic        tdoOut,
	input  wire logic        tdoOe,
	// Collected serial word
	output logic [95:0]      word,
	output logic             wordRdy
);
	logic lastBit = 1'b0;

	// Idle pin levels; the test clock stands still between frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		word = '0;
		wordRdy = 1'b0;
	end

	// mode and data set up while clock low
	task automatic tick(input logic m, input logic d, output logic o);
		@(posedge mclk);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (6) @(posedge mclk);
		// Released line reads as inverse of last bit, never a lucky match
		o = tdoOe ? tdoOut : ~lastBit;
		lastBit = o;
		tck <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask : tick

	// walk from idle through capture, shift and update
	task automatic scan(input logic ir, input int n, input logic [95:0] din);
		logic [95:0] acc;
		logic        o;
		acc = '0;
		tick(1'b1, 1'b0, o);
		if (ir)
			tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			acc[i] = o;
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		word <= acc;
		wordRdy <= 1'b1;
		@(posedge mclk);
		wordRdy <= 1'b0;
	endtask : scan
endmodule : sbst_jtag_ctl

// [sim/testbench.sv]
// Self-checking bench for the boundary-scan test port, 85- and 89-cell chains.
// Assumes the controller model above drives all test pins.
`timescale 1ns/1ps
module testbench;
	import sbst_pkg::*;
	localparam int          CL = CHAIN_119;
	localparam logic [95:0] ID = {ID_VERSION_DEF, ID_PART_DEF, ID_MAKER_DEF, ID_PRESENT};

	logic          mclk = 1'b0;
	logic          reset = 1'b1;
	logic          tck, tms, tdi, tdoOut, tdoOe, memDrvEn_r, wordRdy, b;
	logic [CL-1:0] ringIn = '0;
	logic [CL-1:0] bsrLatch_r;
	logic [95:0]   word, d;
	logic          tck2, tms2, tdi2, tdo2, oe2, en2, rdy2;
	logic [CHAIN_165-1:0] ring2 = '0;
	logic [CHAIN_165-1:0] latch2;
	logic [95:0]   word2;
	logic [95:0]   expQ[$];
	int            err_total = 0;
	int            n_tests = 0;
	int            cyc = 0;
	int            seedTmp;

	always #2 mclk = ~mclk;

	sbst_tap #(.CHAIN_LEN(CL)) uut (.mclk(mclk), .reset(reset), .tck(tck), .tms(tms),
		.tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .ringIn(ringIn),
		.bsrLatch_r(bsrLatch_r), .memDrvEn_r(memDrvEn_r));

	sbst_jtag_ctl ctl (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut),
		.tdoOe(tdoOe), .word(word), .wordRdy(wordRdy));

	// Long-chain variant on its own test pins
	sbst_tap #(.CHAIN_LEN(CHAIN_165)) uut165 (.mclk(mclk), .reset(reset), .tck(tck2),
		.tms(tms2), .tdi(tdi2), .tdoOut(tdo2), .tdoOe(oe2), .ringIn(ring2),
		.bsrLatch_r(latch2), .memDrvEn_r(en2));

	sbst_jtag_ctl ctl2 (.mclk(mclk), .tck(tck2), .tms(tms2), .tdi(tdi2), .tdoOut(tdo2),
		.tdoOe(oe2), .word(word2), .wordRdy(rdy2));

	task automatic finish_test;
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// Level compare on pins sampled between frames
	task automatic check_vec(input logic [95:0] got, input logic [95:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t level got %h exp %h", $time, got, exp);
		end
	endtask : check_vec

	// Serial word compare against the oldest note
	task automatic check_word(input logic [95:0] got);
		logic [95:0] exp;
		exp = '1;
		if (expQ.size() != 0)
			exp = expQ.pop_front();
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t word got %h exp %h", $time, got, exp);
		end
	endtask : check_word

	function automatic logic [95:0] rnd();
		return {$urandom, $urandom, $urandom};
	endfunction : rnd

	// only defined codes loaded; capture shows 001
	task automatic load(input logic [2:0] code);
		expQ.push_back(96'h1);
		ctl.scan(1'b1, 3, {93'h0, code});
	endtask : load

	// Monitor: each finished scan word is judged
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (wordRdy === 1'b1)
			check_word(word);
		if (rdy2 === 1'b1)
			check_word(word2);
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end

	initial begin
		seedTmp = $urandom(32'hDE9CEDB3);
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		check_vec(96'(tdoOe), 96'h0);
		check_vec(96'(memDrvEn_r), 96'h1);
		check_vec(96'(bsrLatch_r), 96'h1 << (CL - 1));
		check_vec(96'(latch2), 96'h1 << (CHAIN_165 - 1));
		ctl.tick(1'b0, 1'b0, b);
		d = rnd();
		expQ.push_back(ID);
		ctl.scan(1'b0, 32, d);
		load(3'h7);
		d = rnd();
		expQ.push_back({88'h0, d[6:0], 1'b0});
		ctl.scan(1'b0, 8, d);
		check_vec(96'(memDrvEn_r), 96'h1);
		check_vec(96'(tdoOe), 96'h0);
		ringIn <= CL'(rnd());
		load(3'h4);
		d = rnd();
		d[CL-1] = 1'b0;
		expQ.push_back(96'(ringIn));
		ctl.scan(1'b0, CL, d);
		check_vec(96'(bsrLatch_r), 96'(d[CL-1:0]));
		check_vec(96'(memDrvEn_r), 96'h1);
		load(3'h0);
		check_vec(96'(memDrvEn_r), 96'h0);
		d = rnd();
		d[CL-1] = 1'b1;
		expQ.push_back(96'(ringIn));
		ctl.scan(1'b0, CL, d);
		check_vec(96'(memDrvEn_r), 96'h1);
		ringIn <= CL'(rnd());
		load(3'h2);
		check_vec(96'(memDrvEn_r), 96'h0);
		expQ.push_back(96'(ringIn));
		ctl.scan(1'b0, CL, rnd());
		check_vec(96'(memDrvEn_r), 96'h0);
		// Five mode-high clocks return to test-logic-reset
		repeat (5) ctl.tick(1'b1, 1'b0, b);
		ctl.tick(1'b0, 1'b0, b);
		check_vec(96'(bsrLatch_r), 96'h1 << (CL - 1));
		check_vec(96'(memDrvEn_r), 96'h1);
		expQ.push_back(ID);
		ctl.scan(1'b0, 32, rnd());
		// Long chain variant: ring capture, full-length shift and latch
		ctl2.tick(1'b0, 1'b0, b);
		ring2 <= CHAIN_165'(rnd());
		expQ.push_back(96'h1);
		ctl2.scan(1'b1, 3, {93'h0, IR_SAMPLE});
		check_vec(96'(en2), 96'h1);
		d = rnd();
		expQ.push_back(96'(ring2));
		ctl2.scan(1'b0, CHAIN_165, d);
		check_vec(96'(latch2), 96'(d[CHAIN_165-1:0]));
		repeat (4) @(posedge mclk);
		finish_test();
	end
endmodule : testbench

// [src/sbst_pkg.sv]
// Constants for the memory boundary-scan test port.
// Assumes one fast system clock that oversamples the test clock pins.
// Notes on behaviour
// - Code 000 selects boundary chain, captures I/O ring, outputs follow latched last cell.
// - Code 001 captures identification value and shifts it; memory unaffected.
// - Code 010 captures ring, selects boundary chain, memory drivers high impedance.
// - Code 100 captures ring into chain and shifts it; memory unaffected.
// - Code 111 selects one-bit bypass register; memory unaffected.
// - 119-ball variant chain is 85 cells; cell 85 internal.
// - 165-ball variant chain is 89 cells; last cell internal.
// - Identification bits 31:29 hold fixed version field.
// - Identification bits 28:12 hold fixed part code.
// - Identification bits 11:1 hold fixed maker code.
// - Identification bit 0 always reads one.
// - Cells for unconnected balls preset low.
// - Internal last tri-state cell preset high.
// - Instruction register is three bits wide.
// - Identification instruction current at power-up and test-logic-reset.
// - Under external test, latched last cell high enables outputs, low floats them.
// - Chain top bit sits next to serial in, bottom next to serial out.
package sbst_pkg;

	localparam int          IR_W       = 3;
	localparam logic [2:0]  IR_EXTEST  = 3'h0;
	localparam logic [2:0]  IR_IDCODE  = 3'h1;
	localparam logic [2:0]  IR_SAMPLEZ = 3'h2;
	localparam logic [2:0]  IR_SAMPLE  = 3'h4;
	localparam logic [2:0]  IR_BYPASS  = 3'h7;
	localparam logic [2:0]  IR_CAPTURE = 3'h1;  // Fixed pattern loaded in capture-IR

	localparam int          CHAIN_119  = 85;
	localparam int          CHAIN_165  = 89;

	// Identification fields; values arbitrary, not tied to any maker
	localparam logic [2:0]  ID_VERSION_DEF = 3'h5;
	localparam logic [16:0] ID_PART_DEF    = 17'h0A5A5;
	localparam logic [10:0] ID_MAKER_DEF   = 11'h2A5;
	localparam logic        ID_PRESENT     = 1'b1;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UP_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
	} sbst_state_type;

endpackage : sbst_pkg

// [src/sbst_tap.sv]
// Boundary-scan test port of the memory: instruction, bypass,
// identification and boundary registers with serial out driver.
// Assumes test pins are asynchronous to mclk and far slower than it.
`timescale 1ns/1ps
module sbst_tap
	import sbst_pkg::*;
#(
	parameter int          CHAIN_LEN  = CHAIN_119,
	parameter logic [2:0]  ID_VERSION = ID_VERSION_DEF,
	parameter logic [16:0] ID_PART    = ID_PART_DEF,
	parameter logic [10:0] ID_MAKER   = ID_MAKER_DEF
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 reset,
	// Test pins
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdoOut,
	output logic                      tdoOe,
	// Memory side
	input  wire logic [CHAIN_LEN-1:0] ringIn,
	output logic [CHAIN_LEN-1:0]      bsrLatch_r,
	output logic                      memDrvEn_r
);

	// unconnected cells low, last cell high
	localparam logic [CHAIN_LEN-1:0] BSR_PRESET = {1'b1, {(CHAIN_LEN-1){1'b0}}};

	localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_PRESENT};

	// Pin synchronisers; first stages feed only second stages
	logic tckS1, tckS2, tckS3, tmsS1, tmsS2, tdiS1, tdiS2;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			{tckS1, tckS2, tckS3} <= 3'h0;
			{tmsS1, tmsS2, tdiS1, tdiS2} <= 4'hF;
		end else begin
			{tckS1, tckS2, tckS3} <= {tck, tckS1, tckS2};
			{tmsS1, tmsS2, tdiS1, tdiS2} <= {tms, tmsS1, tdi, tdiS1};
		end
	end

	// Test clock edge enables
	wire tckRise = tckS2 & ~tckS3;
	wire tckFall = ~tckS2 & tckS3;

	sbst_state_type state;

	sbst_tap_fsm u_fsm (
		.mclk  (mclk),
		.reset (reset),
		.step  (tckRise),
		.tms   (tmsS2),
		.state (state)
	);

	// Registers
	logic [IR_W-1:0]      irShift_r, ir_r;
	logic                 bypass_r;
	logic [31:0]          idShift_r;
	logic [CHAIN_LEN-1:0] bsrShift_r;
	logic                 tdo_r, tdoOe_r;

	// Instruction decode
	wire isExtest  = (ir_r == IR_EXTEST);
	wire isSampleZ = (ir_r == IR_SAMPLEZ);
	wire isIdcode  = (ir_r == IR_IDCODE);
	wire selBsr    = isExtest | isSampleZ | (ir_r == IR_SAMPLE);
	// reserved codes fall back to bypass, the safest path
	wire selBypass = ~selBsr & ~isIdcode;
	wire updBsr    = isExtest | (ir_r == IR_SAMPLE);

	// State decode, qualified by the rising edge except inShft
	wire capIr  = tckRise & (state == ST_CAP_IR);
	wire shIr   = tckRise & (state == ST_SH_IR);
	wire updIr  = tckRise & (state == ST_UP_IR);
	wire inTlr  = tckRise & (state == ST_RESET);
	wire capDr  = tckRise & (state == ST_CAP_DR);
	wire shDr   = tckRise & (state == ST_SH_DR);
	wire updDr  = tckRise & (state == ST_UP_DR);
	wire inShft = (state == ST_SH_DR) | (state == ST_SH_IR);

	// Serial out source for the selected path
	wire tdoSel = (state == ST_SH_IR) ? irShift_r[0] :
	              selBsr              ? bsrShift_r[0] :
	              isIdcode            ? idShift_r[0] : bypass_r;

	// extest follows the latched cell; sample-z floats outputs
	wire memDrvEn_nxt = isExtest ? bsrLatch_r[CHAIN_LEN-1] : ~isSampleZ;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			irShift_r <= IR_CAPTURE;
		else if (capIr)
			irShift_r <= IR_CAPTURE;
		else if (shIr)
			irShift_r <= {tdiS2, irShift_r[IR_W-1:1]};
	end

	// identification instruction on reset and test-logic-reset
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			ir_r <= IR_IDCODE;
		else if (inTlr)
			ir_r <= IR_IDCODE;
		else if (updIr)
			ir_r <= irShift_r;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			bypass_r <= 1'b0;
		else if (capDr & selBypass)
			bypass_r <= 1'b0;
		else if (shDr & selBypass)
			bypass_r <= tdiS2;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			idShift_r <= 32'h0000_0000;
		else if (capDr & isIdcode)
			idShift_r <= ID_VALUE;
		else if (shDr & isIdcode)
			idShift_r <= {tdiS2, idShift_r[31:1]};
	end

	// ring capture; tdi into the top bit
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			bsrShift_r <= BSR_PRESET;
		else if (capDr & selBsr)
			bsrShift_r <= ringIn;
		else if (shDr & selBsr)
			bsrShift_r <= {tdiS2, bsrShift_r[CHAIN_LEN-1:1]};
	end

	// parallel latch, chain length set by variant
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			bsrLatch_r <= BSR_PRESET;
		else if (inTlr)
			bsrLatch_r <= BSR_PRESET;
		else if (updDr & updBsr)
			bsrLatch_r <= bsrShift_r;
	end

	// Memory output driver enable
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			memDrvEn_r <= 1'b1;
		else
			memDrvEn_r <= memDrvEn_nxt;
	end

	// serial out on falling edge, floats outside shift
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tdo_r   <= 1'b0;
			tdoOe_r <= 1'b0;
		end else if (tckFall) begin
			tdo_r   <= tdoSel;
			tdoOe_r <= inShft;
		end
	end

	assign tdoOut = tdo_r;
	assign tdoOe  = tdoOe_r;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence sIrLoad;
		tckRise && state == ST_UP_IR;
	endsequence

	sequence sIdCapture;
		tckRise && state == ST_CAP_DR && isIdcode;
	endsequence

	a_ir_update: assert property (sIrLoad |=> ir_r == $past(irShift_r))
		else $error("instruction not taken on update");
	a_tlr_idcode: assert property (tckRise && state == ST_RESET |=> ir_r == IR_IDCODE)
		else $error("identification not current after test reset");
	a_id_word: assert property (sIdCapture |=> idShift_r == ID_VALUE && idShift_r[0])
		else $error("identification word wrong after capture");
	a_bypass_bit: assert property (shDr && selBypass |=> bypass_r == $past(tdiS2))
		else $error("bypass did not take serial in");
	a_chain_order: assert property (
		shDr && selBsr |=> bsrShift_r[CHAIN_LEN-1] == $past(tdiS2)
		&& bsrShift_r[0] == $past(bsrShift_r[1]))
		else $error("boundary chain shifted wrong way");
	// capture takes the ring as it stands
	a_ring_capture: assert property (
		capDr && selBsr |=> bsrShift_r == $past(ringIn))
		else $error("boundary chain did not capture the ring");
	a_bypass_zero: assert property (
		capDr && selBypass |=> !bypass_r)
		else $error("bypass did not capture zero");
	a_samplez_float: assert property (isSampleZ ##1 isSampleZ |-> !memDrvEn_r)
		else $error("drivers enabled under sample-z");
	a_extest_cell: assert property (
		isExtest ##1 isExtest |-> memDrvEn_r == $past(bsrLatch_r[CHAIN_LEN-1]))
		else $error("output enable not following latched cell");
	// other codes leave the memory alone
	a_mem_free: assert property (
		(!isExtest && !isSampleZ) ##1 (!isExtest && !isSampleZ) |-> memDrvEn_r)
		else $error("memory drivers disturbed by a test instruction");
	// shift state drives the selected low bit
	a_tdo_drive: assert property (
		tckFall && inShft |=> tdoOe && tdoOut == $past(tdoSel))
		else $error("serial out not driving the selected bit");
	a_tdo_float: assert property (tckFall && !inShft |=> !tdoOe)
		else $error("serial out driven outside shift");
	a_tlr_preset: assert property (
		tckRise && state == ST_RESET |=> bsrLatch_r == BSR_PRESET)
		else $error("latched cells not preset in test reset");

endmodule : sbst_tap

// [src/sbst_tap_fsm.sv]
// Test access port controller state machine.
// Advances only on the one-cycle rising-test-clock enable from the top.
`timescale 1ns/1ps
module sbst_tap_fsm
	import sbst_pkg::*;
(
	// Clock and reset
	input  wire logic           mclk,
	input  wire logic           reset,
	// Sampled pins
	input  wire logic           step,
	input  wire logic           tms,
	// State
	output sbst_state_type      state
);

	sbst_state_type stateNxt;

	always_comb begin
		stateNxt = state;
		unique case (state)
			ST_RESET:  stateNxt = tms ? ST_RESET  : ST_IDLE;
			ST_IDLE:   stateNxt = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: stateNxt = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: stateNxt = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  stateNxt = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: stateNxt = tms ? ST_UP_DR  : ST_PA_DR;
			ST_PA_DR:  stateNxt = tms ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: stateNxt = tms ? ST_UP_DR  : ST_SH_DR;
			ST_UP_DR:  stateNxt = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: stateNxt = tms ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: stateNxt = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  stateNxt = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: stateNxt = tms ? ST_UP_IR  : ST_PA_IR;
			ST_PA_IR:  stateNxt = tms ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: stateNxt = tms ? ST_UP_IR  : ST_SH_IR;
			ST_UP_IR:  stateNxt = tms ? ST_SEL_DR : ST_IDLE;
		endcase
	end

	// State register, moves once per test clock rise
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			state <= ST_RESET;
		else if (step)
			state <= stateNxt;
	end

	// Five high mode samples reach reset from anywhere
	logic [2:0] highRun;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			highRun <= 3'h0;
		else if (step)
			highRun <= tms ? ((highRun == 3'h5) ? highRun : highRun + 3'h1) : 3'h0;
	end

	// five mode-high clocks force reset state
	a_five_high_reset: assert property (@(posedge mclk) disable iff (reset)
		highRun == 3'h5 |-> state == ST_RESET)
		else $error("controller not in reset after five mode-high clocks");

endmodule : sbst_tap_fsm
